// ===== design/rsf_buf2.sv
`timescale 1ns/1ns
module rsf_buf2
  import rsf_pkg::*;
#(
  parameter int W = 8
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_reg [2];
  logic wp_reg;
  logic rp_reg;
  logic [1:0] cnt_reg;
  wire logic push = in_valid && in_ready;
  wire logic pop = out_valid && out_ready;
  assign in_ready = (cnt_reg != 2'd2);
  assign out_valid = (cnt_reg != 2'd0);
  assign out_data = mem_reg[rp_reg];
  always_ff @(posedge clk)
  begin
    if (ce && push)
      mem_reg[wp_reg] <= in_data;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      cnt_reg <= 2'd0;
    end
    else if (ce)
    begin
      if (push)
        wp_reg <= ~wp_reg;
      if (pop)
        rp_reg <= ~rp_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : rsf_buf2

// ===== design/rsf_services.sv
`timescale 1ns/1ns
module rsf_services
  import rsf_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int WD_CYCLES = WD_PERIOD
)
(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic SERIAL_LINE_PIN_IN,
  output logic SERIAL_LINE_PIN_OUT,
  output logic LINE_DIRECTION_BIT,
  input wire logic RX_START,
  output logic RX_BUSY,
  output logic RX_VALID,
  input wire logic RX_READY,
  output logic [7:0] RX_DATA,
  output logic RX_CARRY,
  input wire logic TX_START,
  input wire logic [7:0] TX_DATA,
  output logic TX_BUSY,
  input wire logic COPY_START,
  input wire logic [7:0] BLOCK_BASE,
  input wire logic [7:0] BYTE_COUNT,
  input wire logic [15:0] RANGE_START,
  output logic COPY_BUSY,
  output logic [15:0] FLASH_ADDR,
  output logic FLASH_RD,
  input wire logic [7:0] FLASH_RDATA,
  output logic RAM_WE,
  output logic [7:0] RAM_ADDR,
  output logic [7:0] RAM_WDATA,
  input wire logic ERASE_START,
  input wire logic [7:0] SPEED_PARAM,
  input wire logic [15:0] ERASE_ADDR,
  input wire logic IMASK_IN,
  output logic IMASK_OUT,
  output logic ERASE_BUSY,
  output logic ERASE_PULSE,
  output logic ERASE_MASS,
  output logic [15:0] ERASE_PAGE,
  output logic WATCHDOG_KICK
);
  typedef enum {S_IDLE, S_START, S_BITS, S_STOP} rsf_ser_e;
  logic line_meta_reg, line_reg;
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      line_meta_reg <= 1'b1;
      line_reg <= 1'b1;
    end
    else if (CLK_EN)
    begin
      line_meta_reg <= SERIAL_LINE_PIN_IN;
      line_reg <= line_meta_reg;
    end
  end
  // receiver: samples mid-bit, byte lands in a two-entry buffer so a slow reader loses nothing
  rsf_ser_e rx_st_reg;
  logic [7:0] rx_div_reg, rx_sh_reg;
  logic [2:0] rx_n_reg;
  logic rx_push_reg, rx_ok_reg, buf_in_ready, buf_valid;
  logic [8:0] buf_data;
  // the buffer only hands a word on when the output stage is empty or being taken
  logic rx_load;
  assign rx_load = !RX_VALID || RX_READY;
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      rx_st_reg <= S_IDLE;
      rx_div_reg <= 8'h00;
      rx_sh_reg <= 8'h00;
      rx_n_reg <= 3'h0;
      rx_push_reg <= 1'b0;
      rx_ok_reg <= 1'b0;
    end
    else if (CLK_EN)
    begin
      if (rx_push_reg && buf_in_ready)
        rx_push_reg <= 1'b0;
      rx_div_reg <= rx_div_reg - 8'h01;
      case (rx_st_reg)
        S_IDLE:
          if (RX_START && !rx_push_reg)
          begin
            rx_div_reg <= 8'(HALF_DIV - 1);
            rx_st_reg <= S_START;
          end
        // start bit must stay low for half a bit, so a glitch restarts the wait
        S_START:
          if (line_reg)
            rx_div_reg <= 8'(HALF_DIV - 1);
          else if (rx_div_reg == 8'h00)
          begin
            rx_div_reg <= 8'(BAUD_DIV - 1);
            rx_st_reg <= S_BITS;
            rx_n_reg <= 3'h7;
          end
        S_BITS:
          if (rx_div_reg == 8'h00)
          begin
            rx_div_reg <= 8'(BAUD_DIV - 1);
            rx_sh_reg <= {line_reg, rx_sh_reg[7:1]};
            rx_n_reg <= rx_n_reg - 3'h1;
            if (rx_n_reg == 3'h0)
              rx_st_reg <= S_STOP;
          end
        S_STOP:
          if (rx_div_reg == 8'h00)
          begin
            rx_ok_reg <= line_reg;
            rx_push_reg <= 1'b1;
            rx_st_reg <= S_IDLE;
          end
        default:
          rx_st_reg <= S_IDLE;
      endcase
    end
  end
  rsf_buf2 #(
    .W(9)
  ) u_rxbuf (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .ce(CLK_EN),
    .in_valid(rx_push_reg),
    .in_ready(buf_in_ready),
    .in_data({rx_ok_reg, rx_sh_reg}),
    .out_valid(buf_valid),
    .out_ready(rx_load && CLK_EN),
    .out_data(buf_data)
  );
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      RX_VALID <= 1'b0;
      RX_DATA <= 8'h00;
      RX_CARRY <= 1'b0;
      RX_BUSY <= 1'b0;
    end
    else if (CLK_EN)
    begin
      if (rx_load)
      begin
        RX_VALID <= buf_valid;
        RX_DATA <= buf_data[7:0];
        RX_CARRY <= buf_data[8];
      end
      RX_BUSY <= (rx_st_reg != S_IDLE) || rx_push_reg;
    end
  end
  // transmitter: drives low by turning the pin to output; the data bit stays 0
  logic [9:0] tx_sh_reg;
  logic [3:0] tx_n_reg;
  logic [7:0] tx_div_reg;
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      tx_sh_reg <= 10'h3ff;
      tx_n_reg <= 4'h0;
      tx_div_reg <= 8'h00;
      TX_BUSY <= 1'b0;
      LINE_DIRECTION_BIT <= 1'b0;
      SERIAL_LINE_PIN_OUT <= 1'b0;
    end
    else if (CLK_EN)
    begin
      if (!TX_BUSY && TX_START)
      begin
        tx_sh_reg <= {1'b1, TX_DATA, 1'b0};
        tx_n_reg <= 4'd10;
        tx_div_reg <= 8'(BAUD_DIV - 1);
        TX_BUSY <= 1'b1;
        LINE_DIRECTION_BIT <= 1'b1;
      end
      else if (TX_BUSY)
      begin
        tx_div_reg <= tx_div_reg - 8'h01;
        if (tx_div_reg == 8'h00)
        begin
          tx_div_reg <= 8'(BAUD_DIV - 1);
          tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
          tx_n_reg <= tx_n_reg - 4'h1;
          LINE_DIRECTION_BIT <= (tx_n_reg != 4'h1) && !tx_sh_reg[1];
          if (tx_n_reg == 4'h1)
            TX_BUSY <= 1'b0;
        end
      end
    end
  end
  // copy: one flash read per two cycles, written to the data area in order
  logic [7:0] cp_left_reg, cp_ofs_reg;
  logic cp_phase_reg;
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      COPY_BUSY <= 1'b0;
      cp_left_reg <= 8'h00;
      cp_ofs_reg <= 8'h00;
      cp_phase_reg <= 1'b0;
      FLASH_ADDR <= 16'h0000;
      FLASH_RD <= 1'b0;
      RAM_WE <= 1'b0;
      RAM_ADDR <= 8'h00;
      RAM_WDATA <= 8'h00;
    end
    else if (CLK_EN)
    begin
      RAM_WE <= 1'b0;
      FLASH_RD <= 1'b0;
      if (!COPY_BUSY && COPY_START && BYTE_COUNT != 8'h00)
      begin
        COPY_BUSY <= 1'b1;
        cp_left_reg <= BYTE_COUNT;
        cp_ofs_reg <= BLOCK_BASE + OFS_DATA;
        FLASH_ADDR <= RANGE_START;
        FLASH_RD <= 1'b1;
        cp_phase_reg <= 1'b1;
      end
      else if (COPY_BUSY && cp_phase_reg)
      begin
        RAM_WE <= 1'b1;
        RAM_ADDR <= cp_ofs_reg;
        RAM_WDATA <= FLASH_RDATA;
        cp_phase_reg <= 1'b0;
        cp_left_reg <= cp_left_reg - 8'h01;
      end
      else if (COPY_BUSY)
      begin
        if (cp_left_reg == 8'h00)
          COPY_BUSY <= 1'b0;
        else
        begin
          FLASH_ADDR <= FLASH_ADDR + 16'h0001;
          cp_ofs_reg <= cp_ofs_reg + 8'h01;
          FLASH_RD <= 1'b1;
          cp_phase_reg <= 1'b1;
        end
      end
    end
  end
  // erase: fixed pulse length counted in clock-enabled cycles; watchdog kicked during the wait
  logic [31:0] er_cnt_reg, wd_cnt_reg;
  logic imask_save_reg;
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ERASE_BUSY <= 1'b0;
      ERASE_PULSE <= 1'b0;
      ERASE_MASS <= 1'b0;
      ERASE_PAGE <= 16'h0000;
      IMASK_OUT <= 1'b0;
      imask_save_reg <= 1'b0;
      er_cnt_reg <= 32'h0;
      wd_cnt_reg <= 32'h0;
      WATCHDOG_KICK <= 1'b0;
    end
    else if (CLK_EN)
    begin
      WATCHDOG_KICK <= 1'b0;
      if (!ERASE_BUSY)
        IMASK_OUT <= IMASK_IN;
      if (!ERASE_BUSY && ERASE_START)
      begin
        ERASE_BUSY <= 1'b1;
        imask_save_reg <= IMASK_IN;
        IMASK_OUT <= 1'b1;
        ERASE_MASS <= (ERASE_ADDR == BLOCK_PROTECT_ADDR);
        ERASE_PAGE <= {ERASE_ADDR[15:PAGE_AW], {PAGE_AW{1'b0}}};
        ERASE_PULSE <= 1'b1;
        er_cnt_reg <= 32'(ERASE_CYCLES - 1);
        wd_cnt_reg <= 32'(WD_BASE - 1) + WD_MULT * {24'h0, SPEED_PARAM};
      end
      else if (ERASE_BUSY)
      begin
        wd_cnt_reg <= wd_cnt_reg - 32'h1;
        if (wd_cnt_reg == 32'h0)
        begin
          WATCHDOG_KICK <= 1'b1;
          wd_cnt_reg <= 32'(WD_CYCLES - 1);
        end
        er_cnt_reg <= er_cnt_reg - 32'h1;
        if (er_cnt_reg == 32'h0)
        begin
          ERASE_PULSE <= 1'b0;
          ERASE_BUSY <= 1'b0;
          IMASK_OUT <= imask_save_reg;
        end
      end
    end
  end
endmodule : rsf_services

// ===== pkg/rsf_pkg.sv
package rsf_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int BAUD_DIV = 256;
  localparam int HALF_DIV = BAUD_DIV / 2;
  localparam int DATA_BITS = 8;
  localparam int PAGE_BYTES = 64;
  localparam int PAGE_AW = 6;
  localparam logic [15:0] BLOCK_PROTECT_ADDR = 16'hff7e;
  localparam logic [7:0] OFS_SPEED = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h01;
  localparam logic [7:0] OFS_ADDR = 8'h02;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam int ERASE_MIN_US = 4000;
  localparam int ERASE_MAX_US = 5500;
  localparam int ERASE_US = 4500;
  localparam int ERASE_CYC = (ERASE_US * (CLK_HZ / 1000000));
  localparam int WD_BASE = 72;
  localparam int WD_MULT = 3;
  localparam int WD_PERIOD = 20000;
endpackage : rsf_pkg

// ===== test/rsf_checker.sv
`timescale 1ns/1ns
module rsf_checker
  import rsf_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYC
)
(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic TX_START,
  input wire logic TX_BUSY,
  input wire logic SERIAL_LINE_PIN_OUT,
  input wire logic LINE_DIRECTION_BIT,
  input wire logic FLASH_RD,
  input wire logic RAM_WE,
  input wire logic [7:0] RAM_ADDR,
  input wire logic [7:0] BLOCK_BASE,
  input wire logic ERASE_BUSY,
  input wire logic ERASE_PULSE,
  input wire logic ERASE_MASS,
  input wire logic IMASK_OUT,
  input wire logic [15:0] ERASE_ADDR,
  input wire logic [15:0] ERASE_PAGE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // counts pulse cycles, since a repetition cannot span the whole pulse
  int pulse_cnt_reg;
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      pulse_cnt_reg <= 0;
    else if (CLK_EN)
      pulse_cnt_reg <= ERASE_PULSE ? pulse_cnt_reg + 1 : 0;
  end
  chk_pin_data_low: assert property (SERIAL_LINE_PIN_OUT == 1'b0)
    else $error("port data bit not zero");
  chk_tx_launch: assert property (TX_START && !TX_BUSY && CLK_EN
    |=> LINE_DIRECTION_BIT && TX_BUSY) else $error("start bit not launched");
  chk_tx_released: assert property (!TX_BUSY |-> !LINE_DIRECTION_BIT)
    else $error("line held low while idle");
  chk_copy_write: assert property (FLASH_RD |=> RAM_WE)
    else $error("flash read without ram write");
  chk_copy_offset: assert property (RAM_WE |-> (RAM_ADDR - BLOCK_BASE) >= 8'h04)
    else $error("ram write below data array");
  chk_erase_imask: assert property (ERASE_BUSY |-> IMASK_OUT)
    else $error("interrupts open during erase");
  chk_mass_select: assert property (ERASE_PULSE
    |-> ERASE_MASS == (ERASE_ADDR == BLOCK_PROTECT_ADDR)) else $error("erase kind wrong");
  chk_page_match: assert property (ERASE_PULSE && !ERASE_MASS
    |-> ERASE_PAGE[15:6] == ERASE_ADDR[15:6]) else $error("wrong page erased");
  chk_pulse_len: assert property ($fell(ERASE_PULSE) |-> pulse_cnt_reg == ERASE_CYCLES)
    else $error("erase pulse length wrong");
endmodule : rsf_checker
bind rsf_services rsf_checker #(.ERASE_CYCLES(ERASE_CYCLES)) u_chk (
  .CORE_CLK, .SYS_RST, .CLK_EN, .TX_START, .TX_BUSY, .SERIAL_LINE_PIN_OUT,
  .LINE_DIRECTION_BIT, .FLASH_RD, .RAM_WE, .RAM_ADDR, .BLOCK_BASE, .ERASE_BUSY,
  .ERASE_PULSE, .ERASE_MASS, .IMASK_OUT, .ERASE_ADDR, .ERASE_PAGE);

// ===== test/rsf_host.sv
`timescale 1ns/1ns
module rsf_host
  import rsf_pkg::*;
(
  input wire logic clk,
  input wire logic line,
  output logic drv_low
);
  // the host only ever pulls low; the pull-up gives every high level
  initial drv_low = 1'b0;
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  task automatic send(input logic [7:0] b, input logic stop_ok);
    logic [9:0] f;
    f = {stop_ok, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      drv_low = ~f[i];
      step(BAUD_DIV);
    end
    drv_low = 1'b0;
  endtask : send
  task automatic recv(output logic [8:0] f);
    int k;
    k = 0;
    while (line !== 1'b0 && k < 5000)
    begin
      step(1);
      k++;
    end
    step(HALF_DIV);
    for (int i = 0; i < 9; i++)
    begin
      step(BAUD_DIV);
      f[i] = line;
    end
  endtask : recv
endmodule : rsf_host

// ===== test/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import rsf_pkg::*;
;
  localparam int ECYC = 200;
  localparam int LIMIT = 40000;
  logic clk, rst, line, host_low, dir, pin_out, rx_start, rx_busy, rx_valid, rx_ready;
  logic rx_carry, tx_start, tx_busy, cp_start, cp_busy, frd, we, e_start, im_in, im_out;
  logic e_busy, e_pulse, e_mass, kick, ce;
  logic [7:0] rx_data, tx_data, base, cnt, frdata, wa, wd, speed, e;
  logic [15:0] range, fa, e_addr;
  logic [7:0] ram [256];
  logic [8:0] frame;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  assign line = ~(dir | host_low);
  assign frdata = fa[7:0] ^ 8'h5a;
  rsf_host host (.clk(clk), .line(line), .drv_low(host_low));
  rsf_services #(.ERASE_CYCLES(ECYC), .WD_CYCLES(50)) dut (
    .CORE_CLK(clk), .SYS_RST(rst), .CLK_EN(ce), .SERIAL_LINE_PIN_IN(line),
    .SERIAL_LINE_PIN_OUT(pin_out), .LINE_DIRECTION_BIT(dir), .RX_START(rx_start),
    .RX_BUSY(rx_busy), .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_DATA(rx_data),
    .RX_CARRY(rx_carry), .TX_START(tx_start), .TX_DATA(tx_data), .TX_BUSY(tx_busy),
    .COPY_START(cp_start), .BLOCK_BASE(base), .BYTE_COUNT(cnt), .RANGE_START(range),
    .COPY_BUSY(cp_busy), .FLASH_ADDR(fa), .FLASH_RD(frd), .FLASH_RDATA(frdata),
    .RAM_WE(we), .RAM_ADDR(wa), .RAM_WDATA(wd), .ERASE_START(e_start),
    .SPEED_PARAM(speed), .ERASE_ADDR(e_addr), .IMASK_IN(im_in), .IMASK_OUT(im_out),
    .ERASE_BUSY(e_busy), .ERASE_PULSE(e_pulse), .ERASE_MASS(e_mass),
    .ERASE_PAGE(), .WATCHDOG_KICK(kick));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (we === 1'b1)
      ram[wa] = wd;
    if (cyc == LIMIT)
    begin
      err_total++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic wait_for(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 4000)
    begin
      tick(1);
      n++;
    end
  endtask : wait_for
  // a stalled reader must still find the word later, so ready stays low until checked
  task automatic rx_char(input logic [7:0] b, input logic ok, input int stall);
    rx_start = 1'b1;
    tick(1);
    rx_start = 1'b0;
    tick(40);
    cmp_val(rx_busy, 1'b1);
    cmp_val(rx_valid, 1'b0);
    host.send(b, ok);
    wait_for(rx_valid, 1'b1);
    tick(stall);
    cmp_val(rx_data, b);
    cmp_val(rx_carry, ok);
    cmp_val(im_out, 1'b1);
    rx_ready = 1'b1;
    tick(1);
    rx_ready = 1'b0;
    cmp_val(rx_valid, 1'b0);
    $display("rx test done");
  endtask : rx_char
  task automatic tx_char(input logic [7:0] b);
    tx_data = b;
    tx_start = 1'b1;
    tick(1);
    tx_start = 1'b0;
    host.recv(frame);
    cmp_val({7'h00, frame}, {8'h01, b});
    wait_for(tx_busy, 1'b0);
    cmp_val(dir, 1'b0);
    $display("tx test done");
  endtask : tx_char
  task automatic erase(input logic [15:0] a, input logic im);
    e_addr = a;
    im_in = im;
    speed = 8'h14;
    e_start = 1'b1;
    tick(1);
    e_start = 1'b0;
    wait_for(kick, 1'b1);
    cmp_val(16'(n), 16'(WD_BASE + WD_MULT * 20));
    cmp_val(im_out, 1'b1);
    cmp_val(e_mass, a == BLOCK_PROTECT_ADDR);
    // a frozen clock enable must stretch the pulse by exactly the frozen cycles
    ce = 1'b0;
    tick(30);
    cmp_val(e_pulse, 1'b1);
    ce = 1'b1;
    wait_for(e_busy, 1'b0);
    cmp_val(16'(n), 16'(ECYC - WD_BASE - WD_MULT * 20));
    tick(1);
    cmp_val(im_out, im);
    $display("erase test done");
  endtask : erase
  initial
  begin
    {rst, rx_start, rx_ready, tx_start, cp_start, e_start, im_in} = 7'h40;
    {tx_data, base, cnt, speed, range, e_addr} = 64'h0;
    ce = 1'b1;
    ram[8'h23] = 8'hee;
    ram[8'h27] = 8'hee;
    tick(4);
    rst = 1'b0;
    im_in = 1'b1;
    cmp_val(dir, 1'b0);
    rx_char(8'ha5, 1'b1, 300);
    rx_char(8'h3c, 1'b0, 0);
    tx_char(8'h55);
    tx_char(8'hc3);
    base = 8'h20;
    cnt = 8'h03;
    range = 16'hff3e;
    cp_start = 1'b1;
    tick(1);
    cp_start = 1'b0;
    tick(2);
    wait_for(cp_busy, 1'b0);
    tick(2);
    for (int i = 0; i < 5; i++)
    begin
      e = (i == 0 || i == 4) ? 8'hee : (range[7:0] + 8'(i - 1)) ^ 8'h5a;
      cmp_val(ram[8'h23 + 8'(i)], e);
    end
    $display("copy test done");
    erase(16'he121, 1'b0);
    erase(BLOCK_PROTECT_ADDR, 1'b1);
    summarize();
  end
endmodule : tb_top
